/* rtl/tch_config_header.sv */
// Purpose: Type-0 configuration header command, status and misc fields
// Assumes: Configuration requests arrive one per cycle on the core clock
// Notes: Read data registered, one cycle after the request
//
// Functional notes
// - Interrupt disable bit 10 blocks new INTx assert messages; resets zero.
// - Outstanding INTx assertion still gets its deassert after disable.
// - Bit 8 enables reporting fatal and non-fatal errors upstream.
// - Bit 6 parity error response, read-write, resets zero.
// - Bus master enable bit 2 always reads zero.
// - Bit 1 clear makes memory requests get Unsupported Request.
// - Bit 0 clear makes IO requests get Unsupported Request.
// - Command bits 9,7,5,4,3 read zero; bits 15 to 11 read-only.
// - Status bit 15 sets on any received poisoned TLP.
// - Status bit 14 sets when error message sent with enable on.
// - Bits 13 and 12 set on received UR and CA completions.
// - Bit 11 sets when function completes with Completer Abort.
// - Bit 8 sets on poisoned completion or write, parity enabled.
// - Status bits 10,9,7,5 zero; bits 6 and 2 to 0 reserved.
// - Status bit 4 always reads one: capability list present.
// - Class code reads 07h, 00h, 02h.
// - Cache line size byte is plain read-write storage.
// - Latency timer reads zero.
// - Header type reads 00h: single function, target layout.
// - SELF_TEST_CONTROL: capable bit, self-clearing start, completion code nibble.
// - Writing one clears a status error flag; zero leaves it.
`timescale 1ns/1ps
module tch_config_header
  import tch_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Configuration access
  input wire tch_pkg::tch_cfg_req_type cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // Transaction layer events
  input wire tch_pkg::tch_events_type events,
  input wire logic err_detected,
  // Incoming request decode
  input wire logic mem_req,
  input wire logic io_req,
  output logic req_unsupported,
  // Error reporting
  output logic err_msg_req,
  // Legacy interrupt
  input wire logic irq_level,
  input wire logic intx_msg_ready,
  output logic intx_assert_req,
  output logic intx_deassert_req,
  // Self test
  input wire logic self_test_control_done,
  input wire logic [3:0] self_test_control_code,
  output logic self_test_control_start,
  // Control view
  output tch_pkg::tch_ctrl_type ctrl
);

  // ----------------------------------------------------------------
  // Byte-enable write mask
  // ----------------------------------------------------------------
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] status;
    logic [7:0] cache_line;
    logic self_test_control_run;
    logic [7:0] self_test_control_cnt;
    logic [3:0] self_test_control_result;
    logic [31:0] rdata;
    logic rvalid;
  } tch_hdr_state_type;

  tch_hdr_state_type state_reg;
  tch_hdr_state_type state_next;

  logic intx_pending;
  logic [31:0] wmask;
  logic wr_cmd;
  logic wr_misc;
  logic [15:0] st_set;
  logic [15:0] st_clr;
  logic [15:0] cmd_view;
  logic [15:0] st_view;
  logic [7:0] self_test_control_view;

  // ----------------------------------------------------------------
  // Interrupt message sequencer
  // ----------------------------------------------------------------
  tch_intx_ctrl u_intx
  (
    .clock(clock),
    .reset_n(reset_n),
    .intx_dis(state_reg.cmd[TCH_CMD_INTX_DIS]),
    .irq_level(irq_level),
    .msg_ready(intx_msg_ready),
    .assert_req(intx_assert_req),
    .deassert_req(intx_deassert_req),
    .intx_pending(intx_pending)
  );

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  always_comb
  begin
    cmd_view = state_reg.cmd & TCH_CMD_WMASK;
    cmd_view[TCH_CMD_MASTER_EN] = 1'b0;
    st_view = state_reg.status & TCH_ST_W1C_MASK;
    st_view[TCH_ST_CAPLIST] = 1'b1;
    st_view[TCH_ST_INTX] = intx_pending;
    self_test_control_view = '0;
    self_test_control_view[TCH_ST_SELF_TEST_CONTROL_CAPABLE] = TCH_SELF_TEST_CONTROL_IMPL;
    self_test_control_view[TCH_ST_SELF_TEST_CONTROL_START] = state_reg.self_test_control_run;
    self_test_control_view[3:0] = state_reg.self_test_control_result;
  end

  // ----------------------------------------------------------------
  // Status event collection
  // ----------------------------------------------------------------
  always_comb
  begin
    st_set = '0;
    st_set[TCH_ST_DPE] = events.poisoned_rx;
    st_set[TCH_ST_SSE] = events.err_msg_sent &&
      state_reg.cmd[TCH_CMD_SYSERR_EN];
    st_set[TCH_ST_RMA] = events.cpl_ur_rx;
    st_set[TCH_ST_RTA] = events.cpl_ca_rx;
    st_set[TCH_ST_STA] = events.ca_sent;
    st_set[TCH_ST_MDPE] = state_reg.cmd[TCH_CMD_PAR_RESP] &&
      (events.poisoned_cpl_rx || events.poisoned_wr_tx);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    wmask = be_mask(cfg_req.be);
    wr_cmd = cfg_req.wr && (cfg_req.addr == TCH_CMD_STAT_OFF);
    wr_misc = cfg_req.wr && (cfg_req.addr == TCH_MISC_OFF);
    st_clr = '0;

    if (wr_cmd)
    begin
      state_next.cmd = (state_reg.cmd & ~(wmask[15:0] & TCH_CMD_WMASK)) |
        (cfg_req.wdata[15:0] & wmask[15:0] & TCH_CMD_WMASK);
      st_clr = cfg_req.wdata[31:16] & wmask[31:16] &
        TCH_ST_W1C_MASK;
    end
    // Set wins over clear
    state_next.status = ((state_reg.status & ~st_clr) | st_set) &
      TCH_ST_W1C_MASK;

    if (wr_misc && cfg_req.be[0])
    begin
      state_next.cache_line = cfg_req.wdata[7:0];
    end

    // Self test start and self-clear
    if (state_reg.self_test_control_run)
    begin
      if (self_test_control_done)
      begin
        state_next.self_test_control_run = 1'b0;
        state_next.self_test_control_result = self_test_control_code;
      end
    end
    else if (wr_misc && cfg_req.be[3] &&
      cfg_req.wdata[24 + TCH_ST_SELF_TEST_CONTROL_START] && TCH_SELF_TEST_CONTROL_IMPL)
    begin
      state_next.self_test_control_run = 1'b1;
      state_next.self_test_control_result = '0;
    end
    state_next.self_test_control_cnt = '0;

    // Registered read data
    state_next.rvalid = cfg_req.rd;
    state_next.rdata = '0;
    if (cfg_req.rd)
    begin
      case (cfg_req.addr)
        TCH_CMD_STAT_OFF: state_next.rdata = {st_view, cmd_view};
        TCH_CLASS_OFF: state_next.rdata = {TCH_CLASS_CODE,
          TCH_REVISION};
        TCH_MISC_OFF: state_next.rdata = {self_test_control_view, TCH_HDR_TYPE,
          TCH_LAT_TIMER, state_reg.cache_line};
        default: state_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_reg.cmd <= TCH_CMD_RESET;
      state_reg.status <= TCH_ST_RESET;
      state_reg.cache_line <= TCH_CLS_RESET;
      state_reg.self_test_control_run <= 1'b0;
      state_reg.self_test_control_cnt <= '0;
      state_reg.self_test_control_result <= '0;
      state_reg.rdata <= '0;
      state_reg.rvalid <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_rdata = state_reg.rdata;
  assign cfg_rvalid = state_reg.rvalid;
  assign req_unsupported = (mem_req && !state_reg.cmd[TCH_CMD_MEM_EN]) ||
    (io_req && !state_reg.cmd[TCH_CMD_IO_EN]);
  assign err_msg_req = err_detected &&
    state_reg.cmd[TCH_CMD_SYSERR_EN];
  assign self_test_control_start = state_reg.self_test_control_run;
  assign ctrl.io_en = state_reg.cmd[TCH_CMD_IO_EN];
  assign ctrl.mem_en = state_reg.cmd[TCH_CMD_MEM_EN];
  assign ctrl.par_resp = state_reg.cmd[TCH_CMD_PAR_RESP];
  assign ctrl.syserr_en = state_reg.cmd[TCH_CMD_SYSERR_EN];
  assign ctrl.intx_dis = state_reg.cmd[TCH_CMD_INTX_DIS];

endmodule

/* rtl/tch_pkg.sv */
// Purpose: Constants and carriers for the type-0 configuration header bank
// Assumes: Dword-addressed configuration access, byte enables per lane
// Notes: Offsets are configuration byte addresses of the header dwords
package tch_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] TCH_CMD_STAT_OFF = 12'h004;
  localparam logic [11:0] TCH_CLASS_OFF = 12'h008;
  localparam logic [11:0] TCH_MISC_OFF = 12'h00C;

  // ----------------------------------------------------------------
  // Command field positions
  // ----------------------------------------------------------------
  localparam int TCH_CMD_IO_EN = 0;
  localparam int TCH_CMD_MEM_EN = 1;
  localparam int TCH_CMD_MASTER_EN = 2;
  localparam int TCH_CMD_PAR_RESP = 6;
  localparam int TCH_CMD_SYSERR_EN = 8;
  localparam int TCH_CMD_INTX_DIS = 10;
  localparam logic [15:0] TCH_CMD_WMASK = 16'h0543;
  localparam logic [15:0] TCH_CMD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int TCH_ST_INTX = 3;
  localparam int TCH_ST_CAPLIST = 4;
  localparam int TCH_ST_MDPE = 8;
  localparam int TCH_ST_STA = 11;
  localparam int TCH_ST_RTA = 12;
  localparam int TCH_ST_RMA = 13;
  localparam int TCH_ST_SSE = 14;
  localparam int TCH_ST_DPE = 15;
  localparam logic [15:0] TCH_ST_W1C_MASK = 16'hF900;
  localparam logic [15:0] TCH_ST_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Fixed fields
  // ----------------------------------------------------------------
  localparam logic [23:0] TCH_CLASS_CODE = 24'h070002;
  localparam logic [7:0] TCH_REVISION = 8'h01;  // Arbitrary value
  localparam logic [7:0] TCH_HDR_TYPE = 8'h00;
  localparam logic [7:0] TCH_LAT_TIMER = 8'h00;
  localparam logic [7:0] TCH_CLS_RESET = 8'h00;
  localparam int TCH_ST_SELF_TEST_CONTROL_START = 6;
  localparam int TCH_ST_SELF_TEST_CONTROL_CAPABLE = 7;
  localparam logic TCH_SELF_TEST_CONTROL_IMPL = 1'b1;
  localparam logic [7:0] TCH_SELF_TEST_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TCH_SELF_TEST_CONTROL_CYCLES = 8'h10;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } tch_cfg_req_type;

  typedef struct packed {
    logic poisoned_rx;
    logic err_msg_sent;
    logic cpl_ur_rx;
    logic cpl_ca_rx;
    logic ca_sent;
    logic poisoned_cpl_rx;
    logic poisoned_wr_tx;
  } tch_events_type;

  typedef struct packed {
    logic io_en;
    logic mem_en;
    logic par_resp;
    logic syserr_en;
    logic intx_dis;
  } tch_ctrl_type;

endpackage

/* rtl/tch_intx_ctrl.sv */
// Purpose: Legacy INTx assert/deassert message sequencing
// Assumes: Message port accepts one request per cycle when ready
// Notes: Tracks one outstanding assertion
`timescale 1ns/1ps
module tch_intx_ctrl
  import tch_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control
  input wire logic intx_dis,
  input wire logic irq_level,
  // Message port
  input wire logic msg_ready,
  output logic assert_req,
  output logic deassert_req,
  // Status
  output logic intx_pending
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pending;
  } tch_intx_state_type;

  tch_intx_state_type state_reg;
  tch_intx_state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    assert_req = 1'b0;
    deassert_req = 1'b0;
    if (!state_reg.pending)
    begin
      assert_req = irq_level && !intx_dis;
      if (assert_req && msg_ready)
      begin
        state_next.pending = 1'b1;
      end
    end
    else
    begin
      deassert_req = !irq_level || intx_dis;
      if (deassert_req && msg_ready)
      begin
        state_next.pending = 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign intx_pending = state_reg.pending;

endmodule

/* test/tch_header_asserts.sv */
// Purpose: Port assertions for the configuration header bank
// Assumes: Synchronous active-low reset, one clock
// Notes: Bound to every header bank instance
`timescale 1ns/1ps
module tch_header_asserts
  import tch_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Configuration access
  input wire tch_pkg::tch_cfg_req_type cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  // Decode and errors
  input wire logic err_detected,
  input wire logic mem_req,
  input wire logic io_req,
  input wire logic req_unsupported,
  input wire logic err_msg_req,
  // Interrupt and self test
  input wire logic intx_assert_req,
  input wire logic self_test_control_done,
  input wire logic self_test_control_start,
  input wire tch_pkg::tch_ctrl_type ctrl
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  rd_answer_a: assert property (cfg_req.rd |=> cfg_rvalid)
    else $error("read not answered");
  mem_decode_a: assert property (mem_req && !io_req |->
    req_unsupported == !ctrl.mem_en) else $error("memory decode wrong");
  io_decode_a: assert property (io_req && !mem_req |->
    req_unsupported == !ctrl.io_en) else $error("IO decode wrong");
  serr_gate_a: assert property (err_msg_req ==
    (err_detected && ctrl.syserr_en)) else $error("error report wrong");
  intx_block_a: assert property (ctrl.intx_dis |->
    !intx_assert_req) else $error("assert while disabled");
  cmd_fixed_a: assert property (cfg_rvalid &&
    $past(cfg_req.addr) == 12'h004 |-> cfg_rdata[20] &&
    (cfg_rdata & 32'h06E7_FABC) == 32'h0) else $error("fixed bits wrong");
  class_a: assert property (cfg_rvalid &&
    $past(cfg_req.addr) == 12'h008 |-> cfg_rdata[31:8] == 24'h070002)
    else $error("class code wrong");
  misc_fixed_a: assert property (cfg_rvalid &&
    $past(cfg_req.addr) == 12'h00C |-> cfg_rdata[31] &&
    cfg_rdata[29:28] == 2'h0 && cfg_rdata[23:8] == 16'h0)
    else $error("misc byte wrong");
  self_test_control_end_a: assert property (self_test_control_start && self_test_control_done |=>
    !self_test_control_start) else $error("self test start stuck");
  self_test_control_hold_a: assert property (self_test_control_start && !self_test_control_done |=>
    self_test_control_start) else $error("self test start dropped");

  cover property (cfg_rvalid);
  cover property (req_unsupported);
  cover property (self_test_control_start && self_test_control_done);
endmodule

bind tch_config_header tch_header_asserts tch_header_asserts_i (.clock,
  .reset_n, .cfg_req, .cfg_rdata, .cfg_rvalid, .err_detected, .mem_req,
  .io_req, .req_unsupported, .err_msg_req, .intx_assert_req, .self_test_control_done,
  .self_test_control_start, .ctrl);

/* test/tch_msg_port_model.sv */
// Purpose: Upstream message port that takes INTx messages
// Assumes: Request held until ready seen high at an edge
// Notes: Stalls at random, tallies each message kind
`timescale 1ns/1ps
module tch_msg_port_model
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Requests
  input wire logic assert_req,
  input wire logic deassert_req,
  // Acceptance and tallies
  output logic ready,
  output int n_assert,
  output int n_deassert
);
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      ready <= 1'b0;
      n_assert <= 0;
      n_deassert <= 0;
    end
    else
    begin
      if (ready && assert_req)
        n_assert <= n_assert + 1;
      if (ready && deassert_req)
        n_deassert <= n_deassert + 1;
      ready <= ($urandom % 3) == 0;
    end
  end
endmodule

/* test/tch_config_header_bench.sv */
// Purpose: Self-checking bench for the header bank
// Assumes: Message port model stalls at random
// Notes: Read data checked against a queue of notes
`timescale 1ns/1ps
module tch_config_header_bench;
  import tch_pkg::*;
  logic clock, reset_n, err_detected, mem_req, io_req;
  logic irq_level, intx_msg_ready, self_test_control_done, cfg_rvalid;
  logic req_unsupported, err_msg_req, self_test_control_start;
  logic intx_assert_req, intx_deassert_req;
  logic [3:0] self_test_control_code;
  logic [31:0] cfg_rdata, w, c;
  logic [31:0] exp_q[$];
  tch_cfg_req_type cfg_req;
  tch_events_type events;
  tch_ctrl_type ctrl;
  int n_mismatch, compares, cycles, n_assert, n_deassert;

  tch_config_header tch_config_header_i (.clock, .reset_n, .cfg_req,
    .cfg_rdata, .cfg_rvalid, .events, .err_detected, .mem_req, .io_req,
    .req_unsupported, .err_msg_req, .irq_level, .intx_msg_ready,
    .intx_assert_req, .intx_deassert_req, .self_test_control_done, .self_test_control_code,
    .self_test_control_start, .ctrl);
  tch_msg_port_model tch_msg_port_model_i (.clock, .reset_n,
    .assert_req(intx_assert_req), .deassert_req(intx_deassert_req),
    .ready(intx_msg_ready), .n_assert, .n_deassert);

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(logic [31:0] exp);
    compares++;
    if (cfg_rdata !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: read %h expected %h", $time, cfg_rdata, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    cfg_req <= '{1'b1, 1'b0, a, 4'hF, 32'h0};
    exp_q.push_back(e);
    @(posedge clock);
  endtask
  task automatic wr(logic [11:0] a, logic [3:0] b, logic [31:0] d);
    cfg_req <= '{1'b0, 1'b1, a, b, d};
    @(posedge clock);
  endtask
  task automatic idle(int n);
    cfg_req <= '0;
    repeat (n) @(posedge clock);
  endtask
  task automatic ev(tch_events_type v);
    events <= v;
    @(posedge clock);
    events <= '0;
  endtask
  task automatic wait_cnt(ref int cnt, input int k);
    for (int i = 0; i < 60 && cnt != k; i++)
      @(posedge clock);
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  always @(negedge clock)
    if (cfg_rvalid === 1'b1)
      chk_rd(exp_q.size() > 0 ? exp_q.pop_front() : 'x);

  initial
  begin
    reset_n = 1'b0;
    cfg_req = '0;
    events = '0;
    err_detected = 1'b0;
    mem_req = 1'b0;
    io_req = 1'b0;
    irq_level = 1'b0;
    self_test_control_done = 1'b0;
    self_test_control_code = 4'h0;
    void'($urandom(32'h23CE));
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(12'h004, 32'h0010_0000);
    rd(12'h008, {24'h070002, TCH_REVISION});
    rd(12'h00C, 32'h8000_0000);
    rd(12'h010, 32'h0);
    $display("test reset values done");
    wr(12'h004, 4'h3, 32'hFFFF_FFFF);
    rd(12'h004, 32'h0010_0543);
    w = $urandom;
    wr(12'h004, 4'h3, w);
    rd(12'h004, {16'h0010, w[15:0] & 16'h0543});
    idle(1);
    chk(ctrl, {w[0], w[1], w[6], w[8], w[10]});
    for (int k = 0; k < 4; k++)
    begin
      wr(12'h004, 4'h3, k);
      idle(1);
      mem_req <= 1'b1;
      @(negedge clock);
      chk(req_unsupported, !k[1]);
      @(posedge clock);
      mem_req <= 1'b0;
      io_req <= 1'b1;
      @(negedge clock);
      chk(req_unsupported, !k[0]);
      @(posedge clock);
      io_req <= 1'b0;
    end
    $display("test command done");
    err_detected <= 1'b1;
    wr(12'h004, 4'h3, 32'h0143);
    ev(7'h7F);
    rd(12'h004, 32'hF910_0143);
    wr(12'h004, 4'hC, 32'h8000_0000);
    rd(12'h004, 32'h7910_0143);
    wr(12'h004, 4'hC, 32'hFFFF_0000);
    rd(12'h004, 32'h0010_0143);
    wr(12'h004, 4'h3, 32'h0);
    ev(7'h7F);
    rd(12'h004, 32'hB810_0000);
    wr(12'h004, 4'hC, 32'hFFFF_0000);
    idle(1);
    err_detected <= 1'b0;
    $display("test status flags done");
    c = $urandom;
    wr(12'h00C, 4'h7, c);
    rd(12'h00C, {8'h80, 16'h0, c[7:0]});
    wr(12'h00C, 4'h8, 32'h4000_0000);
    idle(1);
    @(negedge clock);
    chk(self_test_control_start, 1'b1);
    rd(12'h00C, {8'hC0, 16'h0, c[7:0]});
    idle(1);
    self_test_control_code <= 4'hA;
    self_test_control_done <= 1'b1;
    @(posedge clock);
    self_test_control_done <= 1'b0;
    rd(12'h00C, {8'h8A, 16'h0, c[7:0]});
    idle(1);
    chk(self_test_control_start, 1'b0);
    $display("test self test done");
    irq_level <= 1'b1;
    wait_cnt(n_assert, 1);
    chk(n_assert, 1);
    idle(2);
    rd(12'h004, 32'h0018_0000);
    wr(12'h004, 4'h3, 32'h0400);
    idle(1);
    wait_cnt(n_deassert, 1);
    chk(n_deassert, 1);
    idle(2);
    rd(12'h004, 32'h0010_0400);
    idle(20);
    chk(n_assert, 1);
    irq_level <= 1'b0;
    $display("test interrupt done");
    idle(2);
    chk(exp_q.size(), 0);
    test_done();
  end
endmodule
